// file: shared/gpio_cell_pkg.sv
// Constants shared by the I/O cell and its edge-selectable register.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package gpio_cell_pkg;
  // Destination codes of the unregistered bypass input.
  localparam logic [1:0] DEST_GLOBAL_CLOCK = 2'h0;
  localparam logic [1:0] DEST_GLOBAL_CTRL  = 2'h1;
  localparam logic [1:0] DEST_SYNTH_REF    = 2'h2;
  localparam logic [1:0] DEST_CAMERA_CLOCK = 2'h3;
  localparam int         DEST_COUNT        = 4;
  // Reset values.
  localparam logic       DATA_RESET        = 1'h0;
  localparam logic [1:0] LANE_RESET        = 2'h0;
endpackage
`default_nettype wire

// file: shared/edge_reg_if.sv
// Carrier between the cell and one edge-selectable register.
// Assumes the register's clock and reset are wired separately.
`timescale 1ns/100ps
`default_nettype none
interface edge_reg_if;
  logic d;
  logic use_fall;
  logic q;
  modport owner (output d, output use_fall, input q);
  modport store (input d, input use_fall, output q);
endinterface
`default_nettype wire

// file: hw/edge_sel_reg.sv
// Single-bit register that triggers on the rising or falling clock edge.
// Assumes use_fall is static while the clock runs.
`timescale 1ns/100ps
`default_nettype none
module edge_sel_reg (
  input  wire logic   clk,
  input  wire logic   rst,
  edge_reg_if.store   port
);
  logic rise_reg;
  logic fall_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rise_reg <= gpio_cell_pkg::DATA_RESET;
    end else begin
      rise_reg <= port.d;
    end
  end

  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      fall_reg <= gpio_cell_pkg::DATA_RESET;
    end else begin
      fall_reg <= port.d;
    end
  end

  assign port.q = port.use_fall ? fall_reg : rise_reg;
endmodule
`default_nettype wire

// file: hw/gpio_io_cell_double_rate_io.sv
// Per-pin I/O cell between core fabric and a bidirectional pad.
// Assumes configuration inputs are static while the side clocks run.
`timescale 1ns/100ps
`default_nettype none
module gpio_io_cell_double_rate_io (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       input_side_clock,
  input  wire logic       output_side_clock,
  input  wire logic       ddr_capable,
  input  wire logic       lvds_single_ended,
  input  wire logic       double_rate_io_req,
  input  wire logic       resync_mode,
  input  wire logic       pull_down_req,
  input  wire logic       in_registered,
  input  wire logic       in_edge_fall,
  input  wire logic       out_registered,
  input  wire logic       out_edge_fall,
  input  wire logic       out_invert,
  input  wire logic       oe_registered,
  input  wire logic       oe_edge_fall,
  input  wire logic [1:0] route_sel,
  input  wire logic       pad_in,
  input  wire logic [1:0] out_data,
  input  wire logic       out_enable,
  output logic      [1:0] in_data,
  output logic            alternate_input,
  output logic            global_clock_net,
  output logic            global_control_net,
  output logic            synth_reference_in,
  output logic            camera_link_clock_in,
  output logic            pad_out,
  output logic            pad_oe_n,
  output logic            pull_down_enable,
  output logic            double_rate_active,
  output logic            double_rate_reject
);
  // ==========================================================================
  // Configuration
  // ==========================================================================
  logic cfg_done_reg;
  logic capable_reg;
  logic lvds_reg;
  logic ddr_active_reg;
  logic ddr_reject_reg;
  logic pull_down_reg;

  // Pin capability straps are caught once, at the first edge after reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_done_reg <= gpio_cell_pkg::DATA_RESET;
      capable_reg  <= gpio_cell_pkg::DATA_RESET;
      lvds_reg     <= gpio_cell_pkg::DATA_RESET;
    end else if (!cfg_done_reg) begin
      cfg_done_reg <= 1'h1;
      capable_reg  <= ddr_capable;
      lvds_reg     <= lvds_single_ended;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ddr_active_reg <= gpio_cell_pkg::DATA_RESET;
      ddr_reject_reg <= gpio_cell_pkg::DATA_RESET;
      pull_down_reg  <= gpio_cell_pkg::DATA_RESET;
    end else begin
      ddr_active_reg <= cfg_done_reg && double_rate_io_req && capable_reg && !lvds_reg;
      ddr_reject_reg <= cfg_done_reg && double_rate_io_req && (!capable_reg || lvds_reg);
      pull_down_reg  <= cfg_done_reg && pull_down_req && !lvds_reg;
    end
  end

  assign double_rate_active = ddr_active_reg;
  assign double_rate_reject = ddr_reject_reg;
  assign pull_down_enable   = pull_down_reg;

  // ==========================================================================
  // Alternate input path
  // ==========================================================================
  function automatic logic dest_hit(input logic [1:0] sel, input logic [1:0] code);
    dest_hit = (sel == code);
  endfunction

  logic [gpio_cell_pkg::DEST_COUNT-1:0] route_fan;

  assign alternate_input = in_registered ? 1'h0 : pad_in;
  generate
    for (genvar g = 0; g < gpio_cell_pkg::DEST_COUNT; g++) begin : g_route
      assign route_fan[g] = alternate_input && dest_hit(route_sel, 2'(g));
    end
  endgenerate
  assign global_clock_net     = route_fan[gpio_cell_pkg::DEST_GLOBAL_CLOCK];
  assign global_control_net   = route_fan[gpio_cell_pkg::DEST_GLOBAL_CTRL];
  assign synth_reference_in   = route_fan[gpio_cell_pkg::DEST_SYNTH_REF];
  assign camera_link_clock_in = route_fan[gpio_cell_pkg::DEST_CAMERA_CLOCK];

  // ==========================================================================
  // Input side
  // ==========================================================================
  edge_reg_if in_if ();
  logic in_rise_reg;
  logic in_fall_reg;
  logic in_fall_rs_reg;

  assign in_if.d        = pad_in;
  assign in_if.use_fall = in_edge_fall;
  edge_sel_reg u_in_reg (
    .clk  (input_side_clock),
    .rst  (rst),
    .port (in_if)
  );

  always_ff @(posedge input_side_clock or posedge rst) begin
    if (rst) begin
      in_rise_reg    <= gpio_cell_pkg::DATA_RESET;
      in_fall_rs_reg <= gpio_cell_pkg::DATA_RESET;
    end else begin
      in_rise_reg    <= pad_in;
      in_fall_rs_reg <= in_fall_reg;
    end
  end

  always_ff @(negedge input_side_clock or posedge rst) begin
    if (rst) begin
      in_fall_reg <= gpio_cell_pkg::DATA_RESET;
    end else begin
      in_fall_reg <= pad_in;
    end
  end

  always_comb begin
    if (ddr_active_reg) begin
      in_data = {resync_mode ? in_fall_rs_reg : in_fall_reg, in_rise_reg};
    end else begin
      in_data = {1'h0, in_registered ? in_if.q : pad_in};
    end
  end

  // ==========================================================================
  // Output side
  // ==========================================================================
  edge_reg_if out_if ();
  edge_reg_if oe_if ();
  logic launch_rise_reg;
  logic launch_fall_reg;
  logic fall_hold_reg;
  logic out_single;
  logic out_ddr;
  logic oe_eff;

  assign out_if.d        = out_data[0];
  assign out_if.use_fall = out_edge_fall;
  assign oe_if.d         = out_enable;
  assign oe_if.use_fall  = oe_edge_fall;
  edge_sel_reg u_out_reg (
    .clk  (output_side_clock),
    .rst  (rst),
    .port (out_if)
  );
  edge_sel_reg u_oe_reg (
    .clk  (output_side_clock),
    .rst  (rst),
    .port (oe_if)
  );

  always_ff @(posedge output_side_clock or posedge rst) begin
    if (rst) begin
      launch_rise_reg <= gpio_cell_pkg::DATA_RESET;
      fall_hold_reg   <= gpio_cell_pkg::DATA_RESET;
    end else begin
      launch_rise_reg <= out_data[0];
      fall_hold_reg   <= out_data[1];
    end
  end

  always_ff @(negedge output_side_clock or posedge rst) begin
    if (rst) begin
      launch_fall_reg <= gpio_cell_pkg::DATA_RESET;
    end else begin
      launch_fall_reg <= resync_mode ? fall_hold_reg : out_data[1];
    end
  end

  assign out_single = out_registered ? (out_if.q ^ out_invert) : out_data[0];
  assign out_ddr    = output_side_clock ? launch_rise_reg : launch_fall_reg;
  assign oe_eff     = oe_registered ? oe_if.q : out_enable;
  assign pad_out    = oe_eff ? (ddr_active_reg ? out_ddr : out_single) : 1'h0;
  assign pad_oe_n   = !oe_eff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence ddr_steady_s;
    ddr_active_reg [*2];
  endsequence

  a_bypass_blocked: assert property (@(posedge ref_clk) disable iff (rst)
    in_registered |-> !alternate_input)
    else $error("Alternate input active while input is registered.");

  a_bypass_route: assert property (@(posedge ref_clk) disable iff (rst)
    !in_registered && route_sel == gpio_cell_pkg::DEST_GLOBAL_CLOCK
      |-> global_clock_net == pad_in && !synth_reference_in)
    else $error("Alternate input misrouted.");

  a_ddr_rise_lane: assert property (@(posedge input_side_clock) disable iff (rst)
    ddr_steady_s |-> in_data[0] == $past(pad_in))
    else $error("Rising input sample not on lane 0.");

  a_resync_align: assert property (@(posedge input_side_clock) disable iff (rst)
    ddr_steady_s ##0 resync_mode |-> in_data[1] == $past(in_fall_reg))
    else $error("Falling input sample not retimed to the rising edge.");

  a_out_rise_lane: assert property (@(posedge output_side_clock) disable iff (rst)
    ddr_steady_s |-> launch_rise_reg == $past(out_data[0]))
    else $error("Rising output lane not launched from lane 0.");

  a_pad_tristate: assert property (@(posedge ref_clk) disable iff (rst)
    pad_oe_n |-> !pad_out)
    else $error("Pad driven while output enable is off.");

  a_ddr_reject: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_done_reg && double_rate_io_req && !capable_reg |=> ddr_reject_reg && !ddr_active_reg)
    else $error("Double rate accepted on an incapable pin.");

  a_lvds_no_pulldown: assert property (@(posedge ref_clk) disable iff (rst)
    lvds_reg |=> !pull_down_enable && !double_rate_active)
    else $error("Pull-down or double rate on a single-ended differential pin.");
endmodule
`default_nettype wire

// file: verif/pad_model.sv
// Far side of the pad: an external driver that shares the wire with the cell.
// Assumes the bench supplies the level that the external driver puts on the pad.
`timescale 1ns/100ps
`default_nettype none
module pad_model (
  input  wire logic pad_out,
  input  wire logic pad_oe_n,
  input  wire logic ext_level,
  output logic      pad_in
);
  // The cell wins the wire while it drives; otherwise the external level shows.
  assign pad_in = pad_oe_n ? ext_level : pad_out;
endmodule
`default_nettype wire

// file: verif/gpio_io_cell_double_rate_io_tb.sv
// Self-checking bench for the I/O cell, with the pad model on its far side.
// Assumes the cell ports as declared and static configuration between tests.
`timescale 1ns/100ps
`default_nettype none
module gpio_io_cell_double_rate_io_tb;
  logic       ref_clk = 0, rst = 1, input_side_clock = 0, output_side_clock = 0;
  logic       ddr_capable = 1, lvds_single_ended = 0, double_rate_io_req = 0;
  logic       resync_mode = 0, pull_down_req = 0, in_registered = 0, in_edge_fall = 0;
  logic       out_registered = 0, out_edge_fall = 0, out_invert = 0;
  logic       oe_registered = 0, oe_edge_fall = 0, out_enable = 1, ext_level = 0;
  logic [1:0] route_sel = 2'h0, out_data = 2'h0, in_data;
  logic       pad_in, alternate_input, global_clock_net, global_control_net;
  logic       synth_reference_in, camera_link_clock_in, pad_out, pad_oe_n;
  logic       pull_down_enable, double_rate_active, double_rate_reject;
  int         err_total = 0, comparisons = 0;
  wire  [3:0] route_nets = {global_clock_net, global_control_net, synth_reference_in,
                            camera_link_clock_in};
  gpio_io_cell_double_rate_io gpio_io_cell_double_rate_io_inst (
    .ref_clk              (ref_clk),
    .rst                  (rst),
    .input_side_clock     (input_side_clock),
    .output_side_clock    (output_side_clock),
    .ddr_capable          (ddr_capable),
    .lvds_single_ended    (lvds_single_ended),
    .double_rate_io_req   (double_rate_io_req),
    .resync_mode          (resync_mode),
    .pull_down_req        (pull_down_req),
    .in_registered        (in_registered),
    .in_edge_fall         (in_edge_fall),
    .out_registered       (out_registered),
    .out_edge_fall        (out_edge_fall),
    .out_invert           (out_invert),
    .oe_registered        (oe_registered),
    .oe_edge_fall         (oe_edge_fall),
    .route_sel            (route_sel),
    .pad_in               (pad_in),
    .out_data             (out_data),
    .out_enable           (out_enable),
    .in_data              (in_data),
    .alternate_input      (alternate_input),
    .global_clock_net     (global_clock_net),
    .global_control_net   (global_control_net),
    .synth_reference_in   (synth_reference_in),
    .camera_link_clock_in (camera_link_clock_in),
    .pad_out              (pad_out),
    .pad_oe_n             (pad_oe_n),
    .pull_down_enable     (pull_down_enable),
    .double_rate_active   (double_rate_active),
    .double_rate_reject   (double_rate_reject)
  );
  pad_model pad_model_inst (
    .pad_out   (pad_out),
    .pad_oe_n  (pad_oe_n),
    .ext_level (ext_level),
    .pad_in    (pad_in)
  );
  // Side clocks are offset so that no edge meets another clock's edge in one time step.
  initial forever #25 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #20 input_side_clock = ~input_side_clock;
  end
  initial begin
    #7;
    forever #30 output_side_clock = ~output_side_clock;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // Straps are caught only once after reset, so each strap set needs a reset.
  task automatic do_reset(input logic cap, input logic lvds);
    rst = 1;
    ddr_capable = cap;
    lvds_single_ended = lvds;
    repeat (16) @(posedge ref_clk);
    #1 rst = 0;
    settle();
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_refuse();
    double_rate_io_req = 1;
    pull_down_req = 1;
    do_reset(1'b0, 1'b0);
    chk({1'h0, double_rate_reject, double_rate_active, pull_down_enable}, 4'h5);
    do_reset(1'b1, 1'b1);
    chk({1'h0, double_rate_reject, double_rate_active, pull_down_enable}, 4'h4);
    do_reset(1'b1, 1'b0);
    chk({2'h0, double_rate_reject, double_rate_active}, 4'h1);
    double_rate_io_req = 0;
    settle();
    $display("test refuse done");
  endtask
  task automatic t_alt();
    out_enable = 0;
    ext_level = 1;
    for (int i = 0; i < 4; i++) begin
      route_sel = i[1:0];
      #5 chk(route_nets, 4'(4'h8 >> i));
    end
    chk({pad_oe_n, pad_out, alternate_input, in_data[0]}, 4'hb);
    chk({2'h0, in_data}, 4'h1);
    in_registered = 1;
    #5 chk({3'h0, alternate_input}, 4'h0);
    chk(route_nets, 4'h0);
    $display("test alternate done");
  endtask
  task automatic t_in_single();
    in_edge_fall = 1;
    @(posedge input_side_clock) #1 ext_level = 0;
    @(negedge input_side_clock) #1 chk({2'h0, in_data}, 4'h0);
    @(posedge input_side_clock) #1 ext_level = 1;
    @(negedge input_side_clock) #1 chk({2'h0, in_data}, 4'h1);
    @(posedge input_side_clock) #1 ext_level = 0;
    in_edge_fall = 0;
    @(negedge input_side_clock) #1 chk({2'h0, in_data}, 4'h1);
    @(posedge input_side_clock) #1 chk({2'h0, in_data}, 4'h0);
    $display("test single input done");
  endtask
  task automatic t_in_ddr();
    double_rate_io_req = 1;
    in_edge_fall = 0;
    for (int r = 0; r < 2; r++) begin
      resync_mode = r[0];
      settle();
      chk({3'h0, double_rate_active}, 4'h1);
      @(posedge input_side_clock) #1 ext_level = 1;
      @(posedge input_side_clock) #1 chk({2'h0, in_data}, 4'h3);
      ext_level = 0;
      @(negedge input_side_clock) #1 chk({2'h0, in_data}, r ? 4'h3 : 4'h1);
      @(posedge input_side_clock) #1 chk({2'h0, in_data}, 4'h0);
    end
    $display("test double rate input done");
  endtask
  task automatic t_out();
    double_rate_io_req = 0;
    out_registered = 1;
    out_invert = 1;
    oe_registered = 1;
    out_enable = 1;
    settle();
    @(posedge output_side_clock) #1 out_data = 2'h0;
    @(posedge output_side_clock) #1 chk({1'h0, pad_oe_n, pad_out, pad_in}, 4'h3);
    out_data = 2'h1;
    #5 chk({2'h0, pad_oe_n, pad_out}, 4'h1);
    @(posedge output_side_clock) #1 chk({2'h0, pad_oe_n, pad_out}, 4'h0);
    out_enable = 0;
    #5 chk({3'h0, pad_oe_n}, 4'h0);
    @(posedge output_side_clock) #1 chk({2'h0, pad_oe_n, pad_out}, 4'h2);
    out_enable = 1;
    out_invert = 0;
    double_rate_io_req = 1;
    for (int r = 0; r < 2; r++) begin
      resync_mode = r[0];
      out_data = 2'h0;
      settle();
      @(posedge output_side_clock) #1 out_data = 2'h2;
      @(negedge output_side_clock) #1 chk({3'h0, pad_out}, r ? 4'h0 : 4'h1);
      @(posedge output_side_clock) #1 chk({3'h0, pad_out}, 4'h0);
      out_data = 2'h1;
      @(negedge output_side_clock) #1 chk({3'h0, pad_out}, r ? 4'h1 : 4'h0);
      @(posedge output_side_clock) #1 chk({2'h0, pad_oe_n, pad_out}, 4'h1);
    end
    double_rate_io_req = 0;
    out_edge_fall = 1;
    oe_edge_fall = 1;
    out_data = 2'h0;
    settle();
    @(posedge output_side_clock) #1 out_data = 2'h1;
    @(negedge output_side_clock) #1 chk({3'h0, pad_out}, 4'h1);
    @(posedge output_side_clock) #1 out_enable = 0;
    chk({2'h0, pad_oe_n, pad_out}, 4'h1);
    @(negedge output_side_clock) #1 chk({2'h0, pad_oe_n, pad_out}, 4'h2);
    $display("test output done");
  endtask
  initial begin
    t_refuse();
    t_alt();
    t_in_single();
    t_in_ddr();
    t_out();
    conclude();
  end
  // The tests take a few microseconds; this span is far beyond that.
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
